// *** rtl/iwd_consts.svh ***
// Offsets, key values, reset values and update timing of the watchdog
`ifndef IWD_CONSTS_SVH
`define IWD_CONSTS_SVH
`define IWD_OFS_KEY     4'h0
`define IWD_OFS_DIV     4'h4
`define IWD_OFS_RLD     4'h8
`define IWD_OFS_STS     4'hc
`define IWD_KEY_REFRESH 16'haaaa
`define IWD_KEY_UNLOCK  16'h5555
`define IWD_KEY_START   16'hcccc
`define IWD_RLD_RESET   12'hfff
`define IWD_DIV_RESET   3'h0
`define IWD_UPD_EDGES   2'h2
`endif

// *** rtl/iwd_pkg.sv ***
// Types shared by the watchdog design
package iwd_pkg;
  typedef enum logic [2:0] {
    IWD_STOPPED = 3'h1,
    IWD_RUNNING = 3'h2,
    IWD_FIRED   = 3'h4
  } iwd_mode_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } iwd_bus_type;

  typedef struct packed {
    logic [15:0]  rdata;
    logic [2:0]   osc_s;
    logic         osc_lvl;
    logic [2:0]   hw_s;
    logic         hw_lvl;
    iwd_mode_type mode;
    logic         unlocked;
    logic [2:0]   div_code;
    logic [2:0]   div_pend;
    logic         div_busy;
    logic [1:0]   div_wait;
    logic [11:0]  rld;
    logic [11:0]  rld_pend;
    logic         rld_busy;
    logic [1:0]   rld_wait;
    logic [7:0]   div_cnt;
    logic [11:0]  cnt;
  } iwd_state_type;
endpackage

// *** rtl/iwd_top.sv ***
// Independent watchdog: key register, divider, reload and down-counter
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "iwd_consts.svh"

module iwd_top (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire iwd_pkg::iwd_bus_type bus,
  output logic [15:0]               reg_rdata,
  input  wire logic                 low_speed_osc,
  input  wire logic                 hw_enable_option,
  input  wire logic                 debug_mode,
  input  wire logic                 debug_freeze,
  input  wire logic                 standby_entry,
  output logic                      wdg_reset_req
);

  // ***********************************************************
  // Decoding
  // ***********************************************************
  function automatic logic [7:0] div_limit(input logic [2:0] code);
    case (code)
      3'h0:    div_limit = 8'h03;
      3'h1:    div_limit = 8'h07;
      3'h2:    div_limit = 8'h0f;
      3'h3:    div_limit = 8'h1f;
      3'h4:    div_limit = 8'h3f;
      3'h5:    div_limit = 8'h7f;
      default: div_limit = 8'hff;
    endcase
  endfunction

  localparam iwd_pkg::iwd_state_type ST_RST = '{
    rld:      `IWD_RLD_RESET,
    rld_pend: `IWD_RLD_RESET,
    cnt:      `IWD_RLD_RESET,
    div_code: `IWD_DIV_RESET,
    mode:     iwd_pkg::IWD_STOPPED,
    default:  '0
  };

  iwd_pkg::iwd_state_type q;
  iwd_pkg::iwd_state_type d;
  logic                   osc_edge;
  logic                   tick;
  logic                   frozen;
  logic                   key_wr;
  logic                   refresh;
  logic                   start;
  logic                   div_wr;
  logic                   rld_wr;

  // Edge counts only once the second and third stages agree
  assign osc_edge = (q.osc_s[2] == q.osc_s[1]) && q.osc_s[2] && !q.osc_lvl;
  // Compare with >= so a code change mid-period cannot stall the tick
  assign tick     = osc_edge &&
                    (q.div_cnt >= div_limit(q.div_code));
  assign frozen   = debug_mode && debug_freeze;
  assign key_wr   = bus.wr && (bus.addr == `IWD_OFS_KEY);
  assign refresh  = key_wr && (bus.wdata == `IWD_KEY_REFRESH);
  assign start    = key_wr && (bus.wdata == `IWD_KEY_START);
  assign div_wr   = bus.wr && (bus.addr == `IWD_OFS_DIV) && q.unlocked &&
                    !q.div_busy;
  assign rld_wr   = bus.wr && (bus.addr == `IWD_OFS_RLD) && q.unlocked &&
                    !q.rld_busy;

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    d = q;
    d.rdata = 16'h0;
    d.osc_s = {q.osc_s[1:0], low_speed_osc};
    d.hw_s  = {q.hw_s[1:0], hw_enable_option};
    if (q.osc_s[2] == q.osc_s[1]) begin
      d.osc_lvl = q.osc_s[2];
    end
    if (q.hw_s[2] == q.hw_s[1]) begin
      d.hw_lvl = q.hw_s[2];
    end

    if (key_wr) begin
      d.unlocked = (bus.wdata == `IWD_KEY_UNLOCK);
    end

    if (osc_edge) begin
      d.div_cnt = tick ? 8'h00 : q.div_cnt + 8'h01;
    end

    if (div_wr) begin
      d.div_pend = bus.wdata[2:0];
      d.div_busy = 1'b1;
      d.div_wait = `IWD_UPD_EDGES;
    end else if (q.div_busy && osc_edge) begin
      if (q.div_wait == 2'h1) begin
        d.div_code = q.div_pend;
        d.div_busy = 1'b0;
      end else begin
        d.div_wait = q.div_wait - 2'h1;
      end
    end

    if (standby_entry) begin
      d.rld      = `IWD_RLD_RESET;
      d.rld_busy = 1'b0;
    end else if (rld_wr) begin
      d.rld_pend = bus.wdata[11:0];
      d.rld_busy = 1'b1;
      d.rld_wait = `IWD_UPD_EDGES;
    end else if (q.rld_busy && osc_edge) begin
      if (q.rld_wait == 2'h1) begin
        d.rld      = q.rld_pend;
        d.rld_busy = 1'b0;
      end else begin
        d.rld_wait = q.rld_wait - 2'h1;
      end
    end

    // Standby does not gate any of this
    case (q.mode)
      iwd_pkg::IWD_STOPPED: begin
        if (start || q.hw_lvl) begin
          d.mode = iwd_pkg::IWD_RUNNING;
        end
      end
      iwd_pkg::IWD_RUNNING: begin
        if (tick && !frozen && (q.cnt == 12'h000)) begin
          d.mode = iwd_pkg::IWD_FIRED;
        end
      end
      iwd_pkg::IWD_FIRED: begin
        d.mode = iwd_pkg::IWD_FIRED;
      end
      default: begin
        d.mode = iwd_pkg::IWD_STOPPED;
      end
    endcase

    if (refresh) begin
      d.cnt = q.rld;
    end else if ((q.mode == iwd_pkg::IWD_RUNNING) && tick && !frozen &&
                 (q.cnt != 12'h000)) begin
      d.cnt = q.cnt - 12'h001;
    end

    if (bus.rd) begin
      case (bus.addr)
        `IWD_OFS_DIV: d.rdata = {13'h0, q.div_code};
        `IWD_OFS_RLD: d.rdata = {4'h0, q.rld};
        `IWD_OFS_STS: d.rdata = {14'h0, q.rld_busy, q.div_busy};
        default:      d.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata     = q.rdata;
  assign wdg_reset_req = q.mode[2];

  // ***********************************************************
  // Checks
  // ***********************************************************
  logic [2:0] div_edges_q;
  logic [2:0] rld_edges_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_edges_q <= 3'h0;
      rld_edges_q <= 3'h0;
    end else begin
      div_edges_q <= !q.div_busy ? 3'h0 : div_edges_q + {2'h0, osc_edge};
      rld_edges_q <= !q.rld_busy ? 3'h0 : rld_edges_q + {2'h0, osc_edge};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_fire_at_zero;
    (q.mode == iwd_pkg::IWD_RUNNING) && tick && !frozen && (q.cnt == 12'h0)
      |=> wdg_reset_req ##1 wdg_reset_req;
  endproperty
  a_fire_at_zero: assert property (p_fire_at_zero)
    else $error("Watchdog reset not raised at zero");

  // Factor worked out from the code, not through the decode function
  property p_tick_period;
    osc_edge && ({1'b0, q.div_cnt} == ((9'h004 << ((q.div_code > 3'h6) ?
      3'h6 : q.div_code)) - 9'h001)) |-> tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Tick off divider period");

  property p_standby_runs;
    (q.mode == iwd_pkg::IWD_RUNNING) && standby_entry && !tick
      |=> q.mode == iwd_pkg::IWD_RUNNING;
  endproperty
  a_standby_runs: assert property (p_standby_runs)
    else $error("Standby stopped the watchdog");

  property p_decrement;
    (q.mode == iwd_pkg::IWD_RUNNING) && tick && !frozen && !refresh &&
      (q.cnt != 12'h0) |=> q.cnt == $past(q.cnt) - 12'h001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("Counter did not step down by one");

  property p_start_only_by_cause;
    $rose(q.mode == iwd_pkg::IWD_RUNNING) |-> $past(start) || $past(q.hw_lvl);
  endproperty
  a_start_only_by_cause: assert property (p_start_only_by_cause)
    else $error("Watchdog started without cause");

  property p_never_stops;
    (q.mode != iwd_pkg::IWD_STOPPED) |=> (q.mode != iwd_pkg::IWD_STOPPED);
  endproperty
  a_never_stops: assert property (p_never_stops)
    else $error("Watchdog stopped before reset");

  property p_hw_start;
    q.hw_lvl && (q.mode == iwd_pkg::IWD_STOPPED) |=>
      q.mode == iwd_pkg::IWD_RUNNING;
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("Hardware option did not start watchdog");

  property p_div_busy;
    div_wr |=> q.div_busy && (q.div_pend == $past(bus.wdata[2:0]));
  endproperty
  a_div_busy: assert property (p_div_busy)
    else $error("Divider busy not raised");

  property p_rld_busy;
    rld_wr && !standby_entry |=> q.rld_busy;
  endproperty
  a_rld_busy: assert property (p_rld_busy)
    else $error("Reload busy not raised");

  property p_refresh;
    refresh |=> q.cnt == $past(q.rld);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("Refresh did not load reload value");

  property p_freeze;
    frozen && !refresh |=> $stable(q.cnt);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Counter moved while frozen");

  property p_locked;
    bus.wr && (bus.addr == `IWD_OFS_DIV) && !q.unlocked |=>
      $stable(q.div_pend);
  endproperty
  a_locked: assert property (p_locked)
    else $error("Locked divider write was taken");

  property p_rld_locked;
    bus.wr && (bus.addr == `IWD_OFS_RLD) && !q.unlocked |=>
      $stable(q.rld_pend);
  endproperty
  a_rld_locked: assert property (p_rld_locked)
    else $error("Locked reload write was taken");

  property p_update_bound;
    (q.div_busy |-> div_edges_q < 3'h3) and
      (q.rld_busy |-> rld_edges_q < 3'h3);
  endproperty
  a_update_bound: assert property (p_update_bound)
    else $error("Update exceeded oscillator cycle bound");

  property p_standby_reload;
    standby_entry |=> q.rld == `IWD_RLD_RESET;
  endproperty
  a_standby_reload: assert property (p_standby_reload)
    else $error("Reload not reinitialised on standby");

  c_fire:    cover property ($rose(wdg_reset_req));
  c_refresh: cover property ((q.mode == iwd_pkg::IWD_RUNNING) && refresh);
  c_div_upd: cover property ($fell(q.div_busy));
  c_rld_upd: cover property ($fell(q.rld_busy));

endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the independent watchdog block
`timescale 1ns/10ps
`include "iwd_consts.svh"

module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  iwd_pkg::iwd_bus_type bus = '0;
  logic [15:0]          reg_rdata;
  logic                 low_speed_osc = 1'b0;
  logic                 hw_enable_option = 1'b0;
  logic                 debug_mode = 1'b0;
  logic                 debug_freeze = 1'b0;
  logic                 standby_entry = 1'b0;
  logic                 wdg_reset_req;
  int                   fail_count = 0;
  int                   n_tests = 0;
  int                   osc_n = 0;
  int                   e0 = 0;
  int                   f = 0;

  always #2.5 clk = ~clk;
  // Oscillator sped up to 10 MHz so divide by 256 fits the run
  always #50 low_speed_osc = ~low_speed_osc;
  always @(posedge low_speed_osc) osc_n++;

  iwd_top DUT (
    .clk              (clk),
    .reset_n          (reset_n),
    .bus              (bus),
    .reg_rdata        (reg_rdata),
    .low_speed_osc    (low_speed_osc),
    .hw_enable_option (hw_enable_option),
    .debug_mode       (debug_mode),
    .debug_freeze     (debug_freeze),
    .standby_entry    (standby_entry),
    .wdg_reset_req    (wdg_reset_req)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // Polls quietly for five oscillator periods, 100 clocks here
  task automatic wait_idle();
    logic [15:0] v;
    v = 16'hffff;
    for (int i = 0; i < 50 && v !== 16'h0000; i++) begin
      rd_reg(`IWD_OFS_STS, v);
    end
    chk(v, 16'h0000);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic cfg(input logic [2:0] c, input logic [11:0] r);
    wr(`IWD_OFS_KEY, `IWD_KEY_UNLOCK);
    wr(`IWD_OFS_DIV, {13'h0000, c});
    wait_idle();
    wr(`IWD_OFS_RLD, {4'h0, r});
    wait_idle();
  endtask

  // Lets the synchroniser swallow the last edge, so none straddles e0
  task automatic osc_align();
    @(posedge low_speed_osc);
    repeat (6) @(posedge clk);
  endtask

  // Divider phase is free, so only a window of edges is known
  task automatic expect_fire(input int lo, input int hi);
    while (wdg_reset_req !== 1'b1 && osc_n - e0 <= hi) @(negedge clk);
    chk(16'(wdg_reset_req === 1'b1 && osc_n - e0 >= lo), 16'h0001);
    @(posedge clk);
  endtask

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #400000;
    fail_count++;
    close_out();
  end

  initial begin
    do_reset();
    chk(16'(wdg_reset_req), 16'h0000);
    rc(`IWD_OFS_DIV, 16'h0000);
    rc(`IWD_OFS_RLD, 16'h0fff);
    rc(`IWD_OFS_STS, 16'h0000);
    rc(`IWD_OFS_KEY, 16'h0000);
    rc(4'h2, 16'h0000);
    wr(`IWD_OFS_RLD, 16'h0005);
    rc(`IWD_OFS_RLD, 16'h0fff);
    wr(`IWD_OFS_KEY, `IWD_KEY_UNLOCK);
    wr(`IWD_OFS_DIV, 16'h0003);
    rc(`IWD_OFS_STS, 16'h0001);
    wait_idle();
    rc(`IWD_OFS_DIV, 16'h0003);
    wr(`IWD_OFS_RLD, 16'h0002);
    rc(`IWD_OFS_STS, 16'h0002);
    wait_idle();
    rc(`IWD_OFS_RLD, 16'h0002);
    wr(`IWD_OFS_KEY, 16'h1234);
    wr(`IWD_OFS_RLD, 16'h0007);
    rc(`IWD_OFS_RLD, 16'h0002);
    @(posedge clk) standby_entry <= 1'b1;
    @(posedge clk) standby_entry <= 1'b0;
    rc(`IWD_OFS_RLD, 16'h0fff);
    // Stopped, then started frozen, then released
    do_reset();
    cfg(3'h0, 12'h001);
    wr(`IWD_OFS_KEY, `IWD_KEY_REFRESH);
    e0 = osc_n;
    wait (osc_n >= e0 + 40);
    @(posedge clk);
    chk(16'(wdg_reset_req), 16'h0000);
    debug_mode <= 1'b1;
    debug_freeze <= 1'b1;
    wr(`IWD_OFS_KEY, `IWD_KEY_START);
    e0 = osc_n;
    wait (osc_n >= e0 + 40);
    chk(16'(wdg_reset_req), 16'h0000);
    osc_align();
    debug_freeze <= 1'b0;
    e0 = osc_n;
    expect_fire(5, 9);
    repeat (50) @(posedge clk);
    chk(16'(wdg_reset_req), 16'h0001);
    debug_mode <= 1'b0;
    // Refreshes every 8 edges hold off a 16-edge timeout
    do_reset();
    cfg(3'h0, 12'h003);
    wr(`IWD_OFS_KEY, `IWD_KEY_START);
    for (int n = 0; n < 6; n++) begin
      wr(`IWD_OFS_KEY, `IWD_KEY_REFRESH);
      e0 = osc_n;
      wait (osc_n >= e0 + 8);
      @(posedge clk);
    end
    chk(16'(wdg_reset_req), 16'h0000);
    osc_align();
    wr(`IWD_OFS_KEY, `IWD_KEY_REFRESH);
    e0 = osc_n;
    expect_fire(13, 17);
    // Every divider code, reload 1 gives two ticks
    for (int c = 0; c < 8; c++) begin
      f = 4 << ((c > 6) ? 6 : c);
      do_reset();
      cfg(3'(c), 12'h001);
      wr(`IWD_OFS_KEY, `IWD_KEY_REFRESH);
      osc_align();
      wr(`IWD_OFS_KEY, `IWD_KEY_START);
      e0 = osc_n;
      @(posedge clk) standby_entry <= 1'b1;
      @(posedge clk) standby_entry <= 1'b0;
      expect_fire(f + 1, 2 * f + 1);
    end
    hw_enable_option <= 1'b1;
    do_reset();
    cfg(3'h0, 12'h001);
    osc_align();
    wr(`IWD_OFS_KEY, `IWD_KEY_REFRESH);
    e0 = osc_n;
    expect_fire(5, 9);
    close_out();
  end
endmodule
